// *** hw/cog_pkg.sv ***
// Constants for the clock output gating and polarity block
package cog_pkg;

  // ----------------------------------------------------------------
  // Bus and array sizing
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 10;
  localparam int IDX_W = 10;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] GLOBAL_IDX = 10'h102;
  localparam logic [IDX_W-1:0] SE_MODE_IDX = 10'h140;
  localparam logic [IDX_W-1:0] STATUS_IDX = 10'h141;

  localparam logic [IDX_W-1:0] OE_IDX [NUM_OUT] = '{
    10'h108, 10'h10D, 10'h112, 10'h117, 10'h11C,
    10'h121, 10'h126, 10'h12B, 10'h130, 10'h13A};
  localparam logic [IDX_W-1:0] DIS_IDX [NUM_OUT] = '{
    10'h109, 10'h10E, 10'h113, 10'h118, 10'h11D,
    10'h122, 10'h127, 10'h12C, 10'h131, 10'h13B};
  localparam logic [IDX_W-1:0] POL_IDX [NUM_OUT] = '{
    10'h10B, 10'h110, 10'h115, 10'h11A, 10'h11F,
    10'h124, 10'h129, 10'h12E, 10'h133, 10'h138};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int KILL_BIT = 0;
  localparam int OE_BIT = 1;
  localparam int SYNC_BIT = 3;
  localparam int IDLE_LSB = 4;
  localparam int POL_LSB = 6;
  localparam int STAT_PIN_BIT = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic KILL_RST = 1'h0;
  localparam logic OE_RST = 1'h0;
  localparam logic SYNC_RST = 1'h1;
  localparam logic [1:0] IDLE_RST = 2'h0;
  localparam logic [1:0] POL_RST = 2'h0;
  localparam logic [NUM_OUT-1:0] SE_MODE_RST = 10'h000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] POL_COMP = 2'h0;
  localparam logic [1:0] POL_SAME = 2'h1;
  localparam logic [1:0] POL_INV = 2'h2;
  localparam logic [1:0] POL_BOTH_INV = 2'h3;
  localparam logic [1:0] IDLE_LOW = 2'h0;
  localparam logic [1:0] IDLE_HIGH = 2'h1;
  localparam logic [1:0] IDLE_MID = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cog_pkg

// *** hw/cog_top.sv ***
// Clock output gating, polarity and disable control with AXI4-Lite regs
//
// Notes on behaviour
// - Single-ended mode drives clock on both pins.
// - Polarity field picks pin relation in single-ended mode, default complementary.
// - Five separate sources can each disable outputs.
// - Global bit zero disables every output.
// - Per-output enable zero disables that output.
// - Disabled output held low, high or mid.
// - Synchronous mode lets running period finish.
// - Asynchronous mode disables at once.
// - Glitch-free gate bit high; resets high.
// - Gate bit low switches asynchronously.
// - Stop-high: plus high, minus low; stop-low reverse; mid both low.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module cog_top #(
  parameter int NUM_OUT = cog_pkg::NUM_OUT,
  parameter int ADDR_W = cog_pkg::ADDR_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic calibration_in_progress,
  input wire logic lock_lost_flag,
  input wire logic enable_pin_active_low_n,
  input wire logic [NUM_OUT-1:0] src_clk,
  output logic [NUM_OUT-1:0] clock_output_pin_p,
  output logic [NUM_OUT-1:0] clock_output_pin_n,
  output logic [NUM_OUT-1:0] idle_mid_level
);

  // ----------------------------------------------------------------
  // Index decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] fld_hit(
    input logic [cog_pkg::IDX_W-1:0] idx,
    input int n
  );
    fld_hit = {idx == cog_pkg::POL_IDX[n], idx == cog_pkg::DIS_IDX[n],
               idx == cog_pkg::OE_IDX[n]};
  endfunction : fld_hit

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic global_output_kill_r;
  logic [NUM_OUT-1:0] per_output_enable_r;
  logic [NUM_OUT-1:0] glitchfree_gate_enable_r;
  logic [1:0] disabled_level_select_r [NUM_OUT];
  logic [1:0] pin_polarity_select_r [NUM_OUT];
  logic [NUM_OUT-1:0] se_mode_r;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_have_r;
  logic w_have_r;
  logic [cog_pkg::IDX_W-1:0] wr_idx_r;
  logic [31:0] wr_data_r;
  logic wr_lane0_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_fire = s_axi_awvalid && awready_r;
  wire w_fire = s_axi_wvalid && wready_r;
  wire wr_commit = aw_have_r && w_have_r && !bvalid_r;
  wire b_done = bvalid_r && s_axi_bready;
  wire wr_en = wr_commit && wr_lane0_r;
  wire wr_global = wr_idx_r == cog_pkg::GLOBAL_IDX;
  wire wr_se = wr_idx_r == cog_pkg::SE_MODE_IDX;
  wire wr_stat = wr_idx_r == cog_pkg::STATUS_IDX;
  wire [NUM_OUT-1:0] wr_oe_hit;
  wire [NUM_OUT-1:0] wr_dis_hit;
  wire [NUM_OUT-1:0] wr_pol_hit;
  wire wr_mapped = wr_global || wr_se || wr_stat || (|wr_oe_hit)
                   || (|wr_dis_hit) || (|wr_pol_hit);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_r <= 1'b0;
      awready_r <= 1'b1;
      wr_idx_r <= '0;
    end else if (aw_fire) begin
      aw_have_r <= 1'b1;
      awready_r <= 1'b0;
      wr_idx_r <= s_axi_awaddr[ADDR_W-1:2];
    end else if (wr_commit) begin
      aw_have_r <= 1'b0;
    end else if (b_done) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      w_have_r <= 1'b0;
      wready_r <= 1'b1;
      wr_data_r <= '0;
      wr_lane0_r <= 1'b0;
    end else if (w_fire) begin
      w_have_r <= 1'b1;
      wready_r <= 1'b0;
      wr_data_r <= s_axi_wdata;
      wr_lane0_r <= s_axi_wstrb[0];
    end else if (wr_commit) begin
      w_have_r <= 1'b0;
    end else if (b_done) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= cog_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? cog_pkg::RESP_OKAY : cog_pkg::RESP_SLVERR;
    end else if (b_done) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      global_output_kill_r <= cog_pkg::KILL_RST;
      se_mode_r <= cog_pkg::SE_MODE_RST;
    end else if (wr_en) begin
      if (wr_global) begin
        global_output_kill_r <= wr_data_r[cog_pkg::KILL_BIT];
      end
      if (wr_se) begin
        se_mode_r <= wr_data_r[NUM_OUT-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [NUM_OUT-1:0] gate_on;
  logic pin_level_r;

  wire [cog_pkg::IDX_W-1:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire ar_fire = s_axi_arvalid && arready_r;
  wire r_done = rvalid_r && s_axi_rready;
  wire rd_global = rd_idx == cog_pkg::GLOBAL_IDX;
  wire rd_se = rd_idx == cog_pkg::SE_MODE_IDX;
  wire rd_stat = rd_idx == cog_pkg::STATUS_IDX;
  wire [NUM_OUT-1:0] rd_oe_hit;
  wire [NUM_OUT-1:0] rd_dis_hit;
  wire [NUM_OUT-1:0] rd_pol_hit;
  wire rd_mapped = rd_global || rd_se || rd_stat || (|rd_oe_hit)
                   || (|rd_dis_hit) || (|rd_pol_hit);
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    if (rd_global) begin
      rd_word[cog_pkg::KILL_BIT] = global_output_kill_r;
    end
    if (rd_se) begin
      rd_word[NUM_OUT-1:0] = se_mode_r;
    end
    if (rd_stat) begin
      rd_word[NUM_OUT-1:0] = gate_on;
      rd_word[cog_pkg::STAT_PIN_BIT] = pin_level_r;
    end
    for (int i = 0; i < NUM_OUT; i++) begin
      if (rd_oe_hit[i]) begin
        rd_word[cog_pkg::OE_BIT] = per_output_enable_r[i];
      end
      if (rd_dis_hit[i]) begin
        rd_word[cog_pkg::SYNC_BIT] = glitchfree_gate_enable_r[i];
        rd_word[cog_pkg::IDLE_LSB +: 2] = disabled_level_select_r[i];
      end
      if (rd_pol_hit[i]) begin
        rd_word[cog_pkg::POL_LSB +: 2] = pin_polarity_select_r[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= cog_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_mapped ? cog_pkg::RESP_OKAY : cog_pkg::RESP_SLVERR;
    end else if (r_done) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Enable pin synchroniser
  // ----------------------------------------------------------------
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
      pin_level_r <= 1'b1;
    end else begin
      pin_s1_r <= enable_pin_active_low_n;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_level_r <= pin_s3_r;
      end
    end
  end

  // Shared enable term, the pin acts low
  wire common_ok = global_output_kill_r && !calibration_in_progress
                   && !lock_lost_flag && !pin_level_r;

  // ----------------------------------------------------------------
  // Per-output gating and pin drive
  // ----------------------------------------------------------------
  logic [NUM_OUT-1:0] disable_r;
  logic [NUM_OUT-1:0] gate_r;
  logic [NUM_OUT-1:0] out_p_r;
  logic [NUM_OUT-1:0] out_n_r;
  logic [NUM_OUT-1:0] mid_r;

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      wire [2:0] wh = fld_hit(wr_idx_r, g);
      wire [2:0] rh = fld_hit(rd_idx, g);
      assign wr_oe_hit[g] = wh[0];
      assign wr_dis_hit[g] = wh[1];
      assign wr_pol_hit[g] = wh[2];
      assign rd_oe_hit[g] = rh[0];
      assign rd_dis_hit[g] = rh[1];
      assign rd_pol_hit[g] = rh[2];

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          per_output_enable_r[g] <= cog_pkg::OE_RST;
          glitchfree_gate_enable_r[g] <= cog_pkg::SYNC_RST;
          disabled_level_select_r[g] <= cog_pkg::IDLE_RST;
          pin_polarity_select_r[g] <= cog_pkg::POL_RST;
        end else if (wr_en) begin
          if (wh[0]) begin
            per_output_enable_r[g] <= wr_data_r[cog_pkg::OE_BIT];
          end
          if (wh[1]) begin
            glitchfree_gate_enable_r[g] <= wr_data_r[cog_pkg::SYNC_BIT];
            disabled_level_select_r[g] <=
              wr_data_r[cog_pkg::IDLE_LSB +: 2];
          end
          if (wh[2]) begin
            pin_polarity_select_r[g] <= wr_data_r[cog_pkg::POL_LSB +: 2];
          end
        end
      end

      // Decision from all sources
      wire kill = !(common_ok && per_output_enable_r[g]);

      // Gate state change waits for a phase boundary in glitch-free mode
      wire at_boundary;
      assign gate_on[g] = glitchfree_gate_enable_r[g] ? gate_r[g]
                          : !disable_r[g];

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          disable_r[g] <= 1'b1;
          gate_r[g] <= 1'b0;
        end else begin
          disable_r[g] <= kill;
          if (at_boundary) begin
            gate_r[g] <= !disable_r[g];
          end
        end
      end

      // Pin levels for the running clock
      wire [1:0] pol = pin_polarity_select_r[g];
      wire run_p = (pol == cog_pkg::POL_INV || pol == cog_pkg::POL_BOTH_INV)
                   ? !src_clk[g] : src_clk[g];
      wire se_n = (pol == cog_pkg::POL_SAME || pol == cog_pkg::POL_INV)
                  ? src_clk[g] : !src_clk[g];
      wire run_n = se_mode_r[g] ? se_n : !run_p;

      // Pin levels while disabled
      wire [1:0] idle = disabled_level_select_r[g];
      wire idle_hi = idle == cog_pkg::IDLE_HIGH;
      wire idle_md = idle == cog_pkg::IDLE_MID;
      wire stop_p = idle_hi;
      wire stop_n = !idle_hi && !idle_md;

      // ----------------------------------------------------------------
      // Gate boundary
      // ----------------------------------------------------------------
      // Running plus level already at stop level, any polarity
      assign at_boundary = run_p == stop_p;

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          out_p_r[g] <= 1'b0;
          out_n_r[g] <= 1'b1;
          mid_r[g] <= 1'b0;
        end else begin
          out_p_r[g] <= gate_on[g] ? run_p : stop_p;
          out_n_r[g] <= gate_on[g] ? run_n : stop_n;
          mid_r[g] <= !gate_on[g] && idle_md;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output assignments
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign clock_output_pin_p = out_p_r;
  assign clock_output_pin_n = out_n_r;
  assign idle_mid_level = mid_r;

endmodule : cog_top

// *** tb/cog_top_assertions.sv ***
// Port assertions for the clock output gating block
`timescale 1ns/1ps
module cog_top_assertions #(
  parameter int NUM_OUT = 10
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic calibration_in_progress,
  input wire logic lock_lost_flag,
  input wire logic enable_pin_active_low_n,
  input wire logic [NUM_OUT-1:0] clock_output_pin_p,
  input wire logic [NUM_OUT-1:0] clock_output_pin_n,
  input wire logic [NUM_OUT-1:0] idle_mid_level
);
  // ----
  // Disable source hold count
  // ----
  logic [4:0] off_cnt_r;
  wire off_src = calibration_in_progress | lock_lost_flag |
    enable_pin_active_low_n;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      off_cnt_r <= 5'h00;
    end else if (!off_src) begin
      off_cnt_r <= 5'h00;
    end else if (off_cnt_r != 5'h1F) begin
      off_cnt_r <= off_cnt_r + 5'h01;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_off_hold;
    off_cnt_r >= 5'h14 |-> $stable(clock_output_pin_p) &&
      $stable(clock_output_pin_n) && $stable(idle_mid_level);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("output moved while disabled");
  property p_mid_quiet;
    (idle_mid_level & (clock_output_pin_p | clock_output_pin_n)) == '0;
  endproperty
  a_mid_quiet: assert property (p_mid_quiet)
    else $error("mid level with a pin driven high");
  property p_pin_lag;
    $fell(enable_pin_active_low_n) && off_cnt_r >= 5'h14 |=>
      $stable(clock_output_pin_p)[*3];
  endproperty
  a_pin_lag: assert property (p_pin_lag)
    else $error("enable pin acted before synchronising");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write response late");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read data late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken during read");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block)
    else $error("write taken during response");
  c_mid: cover property (idle_mid_level[0]);
  c_pin: cover property ($fell(enable_pin_active_low_n) && off_cnt_r > 5'h13);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : cog_top_assertions

bind cog_top cog_top_assertions #(.NUM_OUT(NUM_OUT)) u_cog_top_assertions (
  .mclk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .calibration_in_progress,
  .lock_lost_flag, .enable_pin_active_low_n, .clock_output_pin_p,
  .clock_output_pin_n, .idle_mid_level);

// *** tb/cog_rx_model.sv ***
// Downstream clock receiver that counts short pulses
`timescale 1ns/1ps
module cog_rx_model #(
  parameter int HALF = 4
) (
  input wire logic mclk,
  input wire logic clr,
  input wire logic pin,
  output logic [7:0] runt_cnt
);
  logic last;
  logic armed;
  logic [7:0] run;
  always @(posedge mclk) begin
    if (clr) begin
      runt_cnt <= 8'h00;
      armed <= 1'b0;
      run <= 8'h00;
    end else if (pin !== last) begin
      if (armed && run < HALF) runt_cnt <= runt_cnt + 8'h01;
      armed <= 1'b1;
      run <= 8'h01;
    end else if (run != 8'hFF) begin
      run <= run + 8'h01;
    end
    last <= pin;
  end
endmodule : cog_rx_model

// *** tb/cog_top_test.sv ***
// Self-checking bench for the clock output gating block
`timescale 1ns/1ps
module cog_top_test;
  // ----
  // Signals
  // ----
  logic mclk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, calibration_in_progress;
  logic lock_lost_flag, enable_pin_active_low_n, smp, sel, rx_clr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] src_clk, clock_output_pin_p, clock_output_pin_n;
  logic [9:0] idle_mid_level;
  logic [7:0] runt_cnt;
  logic [2:0] ph;
  logic [33:0] exp_q[$];
  int seed = 90702;
  int n_fail = 0;
  int n_tests = 0;
  wire [2:0] obs = sel ? {2'h0, runt_cnt != 8'h00} : {idle_mid_level[0],
    clock_output_pin_n[0], clock_output_pin_p[0]};
  localparam logic [2:0] IDLE_EXP [4] = '{3'h2, 3'h1, 3'h4, 3'h2};
  localparam logic [1:0] OK = cog_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = cog_pkg::RESP_SLVERR;

  cog_top u_cog_top (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .calibration_in_progress, .lock_lost_flag,
    .enable_pin_active_low_n, .src_clk, .clock_output_pin_p,
    .clock_output_pin_n, .idle_mid_level);
  cog_rx_model u_cog_rx_model (.mclk, .clr(rx_clr),
    .pin(clock_output_pin_p[0]), .runt_cnt);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ph <= ph + 3'h1;
    src_clk <= {9'($random(seed)), ph[2]};
  end
  always @(posedge mclk) begin
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      check("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (smp) check("pins", {31'h0, obs}, exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end

  // ----
  // Tasks
  // ----
  task automatic check(input string nm, input logic [33:0] seen,
    input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc
  task automatic wr(input logic [9:0] i, input logic [7:0] d,
    input logic [1:0] er);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    exp_q.push_back({er, 32'h0});
    while (a || w) begin
      @(posedge mclk);
      if (a && s_axi_awready) begin
        a = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge mclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [33:0] e);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    exp_q.push_back(e);
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  task automatic look(input logic s, input logic [2:0] e);
    sel <= s;
    smp <= 1'b1;
    exp_q.push_back({31'h0, e});
    @(posedge mclk);
    smp <= 1'b0;
    @(posedge mclk);
  endtask : look
  task automatic on_exp(input logic [1:0] pol, input logic se);
    logic s;
    s = src_clk[0];
    look(1'b0, {1'b0, se ? s ^ ~(pol[0] ^ pol[1]) : ~(s ^ pol[1]),
      s ^ pol[1]});
  endtask : on_exp
  task automatic src_set(input int k, input logic off);
    case (k)
      0: wr(cog_pkg::GLOBAL_IDX, {7'h0, !off}, OK);
      1: wr(cog_pkg::OE_IDX[0], {6'h0, !off, 1'b0}, OK);
      2: calibration_in_progress <= off;
      3: lock_lost_flag <= off;
      default: enable_pin_active_low_n <= off;
    endcase
  endtask : src_set
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // ----
  // Main sequence
  // ----
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, calibration_in_progress, lock_lost_flag} = 3'h0;
    {enable_pin_active_low_n, smp, sel, ph, src_clk} = 16'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    rx_clr = 1'b1;
    sys_rst = 1'b1;
    cyc(8);
    sys_rst <= 1'b0;
    rx_clr <= 1'b0;
    @(posedge mclk);
    rd(cog_pkg::GLOBAL_IDX, 34'h0);
    rd(cog_pkg::DIS_IDX[0], 34'h8);
    rd(cog_pkg::POL_IDX[0], 34'h0);
    rd(10'h3FF, {ERR, 32'h0});
    wr(10'h3FF, 8'h01, ERR);
    for (int i = 0; i < 10; i++) wr(cog_pkg::OE_IDX[i], 8'h02, OK);
    cyc(10);
    look(1'b0, 3'h2);
    wr(cog_pkg::GLOBAL_IDX, 8'h01, OK);
    wr(cog_pkg::SE_MODE_IDX, 8'h01, OK);
    for (int i = 0; i < 4; i++) begin
      wr(cog_pkg::POL_IDX[0], {i[1:0], 6'h0}, OK);
      cyc(12);
      on_exp(i[1:0], 1'b1);
    end
    rd(cog_pkg::SE_MODE_IDX, {OK, 32'h1});
    rd(cog_pkg::STATUS_IDX, {OK, 32'h3FF});
    wr(cog_pkg::SE_MODE_IDX, 8'h00, OK);
    cyc(4);
    on_exp(2'h3, 1'b0);
    wr(cog_pkg::SE_MODE_IDX, 8'h01, OK);
    wr(cog_pkg::OE_IDX[0], 8'h00, OK);
    for (int i = 0; i < 4; i++) begin
      wr(cog_pkg::DIS_IDX[0], {2'h0, i[1:0], 4'h0}, OK);
      cyc(4);
      look(1'b0, IDLE_EXP[i]);
    end
    wr(cog_pkg::DIS_IDX[0], 8'h10, OK);
    wr(cog_pkg::OE_IDX[0], 8'h02, OK);
    for (int k = 0; k < 5; k++) begin
      src_set(k, 1'b1);
      cyc(20);
      look(1'b0, 3'h1);
      src_set(k, 1'b0);
      cyc(20);
      on_exp(2'h3, 1'b1);
    end
    for (int m = 0; m < 2; m++) begin
      wr(cog_pkg::DIS_IDX[0], {4'h0, !m[0], 3'h0}, OK);
      rx_clr <= 1'b1;
      @(posedge mclk);
      rx_clr <= 1'b0;
      for (int j = 0; j < 8; j++) begin
        cyc(j + 1);
        calibration_in_progress <= 1'b1;
        cyc(10);
        calibration_in_progress <= 1'b0;
        cyc(10);
      end
      look(1'b1, {2'h0, m[0]});
    end
    print_verdict();
  end
endmodule : cog_top_test
